// >>> asu_pkg.sv
// shared constants and types for the security unlock command block
package asu_pkg;

   // ************************************************************
   // command codes
   // ************************************************************
   localparam logic [7:0] ASU_CMD_SET_PW  = 8'hF1;  // set password
   localparam logic [7:0] ASU_CMD_UNLOCK  = 8'hF2;  // unlock
   localparam logic [7:0] ASU_CMD_ERASE   = 8'hF4;  // erase unit
   localparam logic [3:0] ASU_CMD_SEEK_HI = 4'h7;   // seek group 7Xh

   // ************************************************************
   // register addresses (plain port, 16-bit data)
   // ************************************************************
   localparam logic [3:0] ASU_A_COMMAND = 4'h0;  // write starts command
   localparam logic [3:0] ASU_A_DEVHEAD = 4'h1;  // drive/head
   localparam logic [3:0] ASU_A_CYL_HI  = 4'h2;  // cylinder high
   localparam logic [3:0] ASU_A_CYL_LO  = 4'h3;  // cylinder low
   localparam logic [3:0] ASU_A_SECT    = 4'h4;  // sector number
   localparam logic [3:0] ASU_A_DATA    = 4'h5;  // data sector words
   localparam logic [3:0] ASU_A_STATUS  = 4'h6;  // block status
   localparam logic [3:0] ASU_A_IRQ_ST  = 4'h7;  // sticky events, w1c
   localparam logic [3:0] ASU_A_IRQ_MSK = 4'h8;  // event mask
   localparam logic [3:0] ASU_A_CAP_LLO = 4'h9;  // capacity lba 15:0
   localparam logic [3:0] ASU_A_CAP_LHI = 4'hA;  // capacity lba 27:16
   localparam logic [3:0] ASU_A_CAP_CYL = 4'hB;  // cylinder count
   localparam logic [3:0] ASU_A_CAP_HS  = 4'hC;  // heads 11:8, spt 7:0

   // ************************************************************
   // status bit positions
   // ************************************************************
   localparam int ASU_S_BUSY   = 0;
   localparam int ASU_S_DRQ    = 1;
   localparam int ASU_S_ERR    = 2;
   localparam int ASU_S_ABRT   = 3;
   localparam int ASU_S_IDNF   = 4;
   localparam int ASU_S_LOCKED = 5;
   localparam int ASU_S_ENABLE = 6;
   localparam int ASU_S_LVLMAX = 7;
   localparam int ASU_S_TRY_LO = 8;

   // interrupt event bits
   localparam int ASU_I_DONE = 0;  // command complete
   localparam int ASU_I_DRQ  = 1;  // data sector requested
   localparam int ASU_I_ERR  = 2;  // command ended in error

   // ************************************************************
   // data sector layout
   // ************************************************************
   localparam int         ASU_W_ID_BIT  = 0;      // identifier bit
   localparam int         ASU_W_LVL_BIT = 8;      // security level bit
   localparam logic [7:0] ASU_PW_FIRST  = 8'h01;  // first password word
   localparam logic [7:0] ASU_PW_LAST   = 8'h10;  // word 16
   localparam logic [7:0] ASU_SEC_LAST  = 8'hFF;  // word 255
   localparam int         ASU_DH_LBA    = 6;      // addressing-mode bit

   // ************************************************************
   // counts and reset values
   // ************************************************************
   localparam logic [2:0]  ASU_TRIES_INIT = 3'h5;  // unlock attempts
   localparam logic [27:0] ASU_CAP_LBA_RST = 28'h0000100;
   localparam logic [15:0] ASU_CAP_CYL_RST = 16'h0010;
   localparam logic [3:0]  ASU_CAP_HDS_RST = 4'h4;
   localparam logic [7:0]  ASU_CAP_SPT_RST = 8'h04;

   typedef logic [4:0] asu_maddr_t;  // {master, word index}

   typedef enum logic [1:0] {
      ASU_IDLE,
      ASU_XFER,
      ASU_EVAL
   } asu_state_e;

endpackage : asu_pkg

// >>> asu_pw_mem.sv
// password store: user words 0..15, master words 16..31
`timescale 1ns/1ps
`default_nettype none
module asu_pw_mem
   import asu_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic        WE,
   input  wire asu_maddr_t  WADDR,
   input  wire logic [15:0] WDATA,
   input  wire asu_maddr_t  RADDR,
   output logic      [15:0] RDATA
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [31:0][15:0] mem;    // both passwords
      logic [15:0]       rdata;  // registered read port
   } asu_mem_s;

   asu_mem_s m_r;    // registered state
   asu_mem_s m_nxt;  // next state

   // write port and registered read port
   always_comb begin
      m_nxt       = m_r;
      m_nxt.rdata = m_r.mem[RADDR];
      if (WE) begin
         m_nxt.mem[WADDR] = WDATA;
      end
   end

   // power-on clears both passwords
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         m_r <= '0;
      end else begin
         m_r <= m_nxt;
      end
   end

   assign RDATA = m_r.rdata;

endmodule : asu_pw_mem
`default_nettype wire

// >>> asu_unlock.sv
// security set password / unlock / seek command interpreter
//
// Contract
// - set password takes exactly one data sector
// - word0 identifier, words 1-16 password, rest reserved
// - user at high: user or master unlock
// - user at maximum: only user unlocks
// - master set keeps lock and level
// - unlock takes one sector before acting on the compare
// - master unlock at high compares master
// - master unlock at maximum is rejected
// - user unlock always compares user password
// - mismatch aborts and decrements counter
// - counter starts five, decrements only locked
// - counter zero aborts unlock/erase until reset; erase is aborted at any count
// - unlock while unlocked leaves counter alone
// - seek only range checks the address
`timescale 1ns/1ps
`default_nettype none
module asu_unlock
   import asu_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic        HW_RESET,
   input  wire logic [3:0]  ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [15:0] RDATA,
   output logic             IRQ,
   output logic             LOCKED
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      asu_state_e  st;         // command phase
      logic [7:0]  cmd;        // command being run
      logic [7:0]  devhead;    // drive/head
      logic [7:0]  cyl_hi;     // cylinder high
      logic [7:0]  cyl_lo;     // cylinder low
      logic [7:0]  sect;       // sector number
      logic [7:0]  wcnt;       // data word index
      logic        sel_mst;    // identifier of this sector
      logic        new_max;    // level bit of this sector
      logic        cmp_pend;   // stored word arrives this cycle
      logic [15:0] cmp_word;   // supplied word under compare
      logic        mismatch;   // any password word differed
      logic        err;        // status error
      logic        abrt;       // command aborted
      logic        idnf;       // seek address out of range
      logic        locked;     // access locked
      logic        enabled;    // lock armed for next reset
      logic        lvl_max;    // security level maximum
      logic [2:0]  tries;      // unlock attempts left
      logic [2:0]  irq_st;     // sticky events
      logic [2:0]  irq_msk;    // event mask
      logic        irq;        // interrupt level
      logic [15:0] rdata;      // read data
      logic [27:0] cap_lba;    // lba capacity
      logic [15:0] cap_cyl;    // cylinders
      logic [3:0]  cap_hds;    // heads
      logic [7:0]  cap_spt;    // sectors per track
   } asu_main_s;

   asu_main_s  s_r;       // registered state
   asu_main_s  s_nxt;     // next state
   logic       mem_we;    // password write
   asu_maddr_t mem_wa;    // write address
   asu_maddr_t mem_ra;    // read address
   logic [15:0] mem_rd;   // stored word, one cycle after mem_ra

   // ************************************************************
   // password store
   // ************************************************************
   asu_pw_mem u_mem (
      .SYS_CLK (SYS_CLK),
      .RST_N   (RST_N),
      .WE      (mem_we),
      .WADDR   (mem_wa),
      .WDATA   (WDATA),
      .RADDR   (mem_ra),
      .RDATA   (mem_rd)
   );

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb begin
      logic [2:0]  ev;       // events raised this cycle
      logic [27:0] lba;      // seek address as lba
      logic [15:0] cyl;      // seek cylinder
      logic        oor;      // seek out of range
      logic        fail;     // unlock outcome
      logic        do_wr;    // data word write
      logic [7:0]  pw_idx;   // password word index
      ev     = '0;
      lba    = '0;
      cyl    = '0;
      oor    = 1'b0;
      fail   = 1'b0;
      do_wr  = WR && (ADDR == ASU_A_DATA);
      pw_idx = s_r.wcnt - ASU_PW_FIRST;
      s_nxt  = s_r;
      mem_we = 1'b0;
      mem_wa = {s_r.sel_mst, pw_idx[3:0]};
      mem_ra = {s_r.sel_mst, pw_idx[3:0]};

      // stored word arrives: fold the compare into the result
      s_nxt.cmp_pend = 1'b0;
      if (s_r.cmp_pend && (mem_rd != s_r.cmp_word)) begin
         s_nxt.mismatch = 1'b1;
      end

      // read port: data stands in the next cycle only
      s_nxt.rdata = '0;
      if (RD) begin
         case (ADDR)
            ASU_A_DEVHEAD: s_nxt.rdata = {8'h00, s_r.devhead};
            ASU_A_CYL_HI:  s_nxt.rdata = {8'h00, s_r.cyl_hi};
            ASU_A_CYL_LO:  s_nxt.rdata = {8'h00, s_r.cyl_lo};
            ASU_A_SECT:    s_nxt.rdata = {8'h00, s_r.sect};
            ASU_A_STATUS:  s_nxt.rdata = {5'h00, s_r.tries, s_r.lvl_max,
                                          s_r.enabled, s_r.locked,
                                          s_r.idnf, s_r.abrt, s_r.err,
                                          s_r.st == ASU_XFER,
                                          s_r.st != ASU_IDLE};
            ASU_A_IRQ_ST:  s_nxt.rdata = {13'h0000, s_r.irq_st};
            ASU_A_IRQ_MSK: s_nxt.rdata = {13'h0000, s_r.irq_msk};
            ASU_A_CAP_LLO: s_nxt.rdata = s_r.cap_lba[15:0];
            ASU_A_CAP_LHI: s_nxt.rdata = {4'h0, s_r.cap_lba[27:16]};
            ASU_A_CAP_CYL: s_nxt.rdata = s_r.cap_cyl;
            ASU_A_CAP_HS:  s_nxt.rdata = {4'h0, s_r.cap_hds,
                                          s_r.cap_spt};
            default:       s_nxt.rdata = '0;  // unmapped and data port
         endcase
      end

      // plain register writes; task file held while a command runs
      if (WR && (s_r.st == ASU_IDLE)) begin
         case (ADDR)
            ASU_A_DEVHEAD: s_nxt.devhead = WDATA[7:0];
            ASU_A_CYL_HI:  s_nxt.cyl_hi  = WDATA[7:0];
            ASU_A_CYL_LO:  s_nxt.cyl_lo  = WDATA[7:0];
            ASU_A_SECT:    s_nxt.sect    = WDATA[7:0];
            ASU_A_CAP_LLO: s_nxt.cap_lba[15:0]  = WDATA;
            ASU_A_CAP_LHI: s_nxt.cap_lba[27:16] = WDATA[11:0];
            ASU_A_CAP_CYL: s_nxt.cap_cyl = WDATA;
            ASU_A_CAP_HS:  begin
               s_nxt.cap_hds = WDATA[11:8];
               s_nxt.cap_spt = WDATA[7:0];
            end
            default: ;  // command handled below
         endcase
      end
      if (WR && (ADDR == ASU_A_IRQ_MSK)) begin
         s_nxt.irq_msk = WDATA[2:0];
      end

      case (s_r.st)
         // ---- wait for a command write ----
         ASU_IDLE: begin
            if (WR && (ADDR == ASU_A_COMMAND)) begin
               s_nxt.cmd      = WDATA[7:0];
               s_nxt.err      = 1'b0;
               s_nxt.abrt     = 1'b0;
               s_nxt.idnf     = 1'b0;
               s_nxt.mismatch = 1'b0;
               s_nxt.wcnt     = '0;
               if ((WDATA[7:0] == ASU_CMD_SET_PW) ||
                   (WDATA[7:0] == ASU_CMD_UNLOCK)) begin
                  // one data sector is requested first
                  s_nxt.st   = ASU_XFER;
                  ev[ASU_I_DRQ] = 1'b1;
               end else if (WDATA[7:4] == ASU_CMD_SEEK_HI) begin
                  // no positioning, range check only
                  lba = {s_r.devhead[3:0], s_r.cyl_hi, s_r.cyl_lo,
                         s_r.sect};
                  cyl = {s_r.cyl_hi, s_r.cyl_lo};
                  if (s_r.devhead[ASU_DH_LBA]) begin
                     oor = (lba >= s_r.cap_lba);
                  end else begin
                     oor = (cyl >= s_r.cap_cyl) ||
                           (s_r.devhead[3:0] >= s_r.cap_hds) ||
                           (s_r.sect == 8'h00) ||
                           (s_r.sect > s_r.cap_spt);
                  end
                  s_nxt.err  = oor;
                  s_nxt.idnf = oor;
                  ev[ASU_I_DONE] = 1'b1;
                  ev[ASU_I_ERR]  = oor;
               end else begin
                  // erase unit and all else: aborted here
                  s_nxt.err  = 1'b1;
                  s_nxt.abrt = 1'b1;
                  ev[ASU_I_DONE] = 1'b1;
                  ev[ASU_I_ERR]  = 1'b1;
               end
            end
         end

         // ---- take the 256 words of the data sector ----
         ASU_XFER: begin
            if (do_wr) begin
               s_nxt.wcnt = s_r.wcnt + 8'h01;
               if (s_r.wcnt == 8'h00) begin
                  // control word: identifier and level
                  s_nxt.sel_mst = WDATA[ASU_W_ID_BIT];
                  s_nxt.new_max = WDATA[ASU_W_LVL_BIT];
               end else if (s_r.wcnt <= ASU_PW_LAST) begin
                  if (s_r.cmd == ASU_CMD_SET_PW) begin
                     // store into the selected slot, not while locked
                     mem_we = !s_r.locked;
                  end else begin
                     // fetch stored word, compare next cycle
                     s_nxt.cmp_pend = 1'b1;
                     s_nxt.cmp_word = WDATA;
                  end
               end
               if (s_r.wcnt == ASU_SEC_LAST) begin
                  s_nxt.st = ASU_EVAL;
               end
            end
         end

         // ---- whole sector taken: act on it ----
         ASU_EVAL: begin
            s_nxt.st = ASU_IDLE;
            ev[ASU_I_DONE] = 1'b1;
            if (s_r.cmd == ASU_CMD_SET_PW) begin
               if (s_r.locked) begin
                  fail = 1'b1;  // words were dropped above
               end else if (!s_r.sel_mst) begin
                  // arm lock for next reset; level picks unlockers
                  s_nxt.enabled = 1'b1;
                  s_nxt.lvl_max = s_r.new_max;
               end
               // master set: lock and level untouched
            end else if (s_r.tries == 3'h0) begin
               fail = 1'b1;
            end else if (s_r.sel_mst && s_r.lvl_max) begin
               fail = 1'b1;
            end else if (s_r.mismatch) begin
               fail = 1'b1;
               if (s_r.locked) begin
                  s_nxt.tries = s_r.tries - 3'h1;
               end
            end else begin
               s_nxt.locked = 1'b0;
            end
            s_nxt.err  = fail;
            s_nxt.abrt = fail;
            ev[ASU_I_ERR] = fail;
         end

         default: s_nxt.st = ASU_IDLE;
      endcase

      // sticky events: a new event wins over a write-one clear
      if (WR && (ADDR == ASU_A_IRQ_ST)) begin
         s_nxt.irq_st = s_r.irq_st & ~WDATA[2:0];
      end
      s_nxt.irq_st = s_nxt.irq_st | ev;

      // hardware reset: lock re-arms, attempts refill
      if (HW_RESET) begin
         s_nxt.st       = ASU_IDLE;
         s_nxt.locked   = s_r.enabled;
         s_nxt.tries    = ASU_TRIES_INIT;
         s_nxt.cmp_pend = 1'b0;
         s_nxt.err      = 1'b0;
         s_nxt.abrt     = 1'b0;
         s_nxt.idnf     = 1'b0;
      end

      s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_msk);
   end

   // ************************************************************
   // state register; power-on leaves no password armed
   // ************************************************************
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_r         <= '0;
         s_r.st      <= ASU_IDLE;
         s_r.tries   <= ASU_TRIES_INIT;
         s_r.cap_lba <= ASU_CAP_LBA_RST;
         s_r.cap_cyl <= ASU_CAP_CYL_RST;
         s_r.cap_hds <= ASU_CAP_HDS_RST;
         s_r.cap_spt <= ASU_CAP_SPT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign RDATA  = s_r.rdata;
   assign IRQ    = s_r.irq;
   assign LOCKED = s_r.locked;

endmodule : asu_unlock
`default_nettype wire

// >>> asu_unlock_asserts.sv
// assertion checker for the security unlock command block
`timescale 1ns/1ps
`default_nettype none
module asu_unlock_asserts
   import asu_pkg::*;
(
   input wire logic        SYS_CLK,
   input wire logic        RST_N,
   input wire logic        HW_RESET,
   input wire logic [3:0]  ADDR,
   input wire logic [15:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [15:0] RDATA,
   input wire logic        IRQ,
   input wire logic        LOCKED
);
   // ************************************************************
   // one clock domain, power-on reset disables everything
   // ************************************************************
   default clocking dc @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   // read data only stand in the cycle after a read strobe
   a_rdata_quiet: assert property (!RD |=> RDATA == 16'h0000)
      else $error("read data not zero outside a read");
   // data port and unmapped addresses read as zero
   a_unmapped_read: assert property ((RD && (ADDR > ASU_A_CAP_HS ||
      ADDR == ASU_A_DATA)) |=> RDATA == 16'h0000)
      else $error("unmapped read returned data");
   a_status_lock: assert property (
      (RD && ADDR == ASU_A_STATUS) |=> RDATA[ASU_S_LOCKED] == $past(LOCKED))
      else $error("status lock bit differs from lock pin");
   // locking only ever starts at a hardware reset
   a_lock_rise: assert property ($rose(LOCKED) |-> $past(HW_RESET))
      else $error("lock rose without hardware reset");
   // unlock lands two cycles after the last sector word
   a_unlock_cause: assert property ($fell(LOCKED) |->
      ($past(HW_RESET) || ($past(WR, 2) && $past(ADDR, 2) == ASU_A_DATA)))
      else $error("lock dropped without cause");
   a_tries_bound: assert property (
      (RD && ADDR == ASU_A_STATUS) |=> RDATA[10:8] <= ASU_TRIES_INIT)
      else $error("attempt counter above its start value");
   a_hw_tries: assert property (
      HW_RESET ##2 (RD && ADDR == ASU_A_STATUS) |=>
      RDATA[10:8] == ASU_TRIES_INIT)
      else $error("attempt counter not restored by hardware reset");
   // a cleared mask silences the line at the very next edge
   a_mask_quiet: assert property ((WR && ADDR == ASU_A_IRQ_MSK &&
      WDATA[2:0] == 3'h0) |=> !IRQ)
      else $error("interrupt high with all events masked");

   c_lock: cover property ($rose(LOCKED));
   c_unlock: cover property ($fell(LOCKED));
   c_irq: cover property ($rose(IRQ));
endmodule : asu_unlock_asserts

bind asu_unlock asu_unlock_asserts i_asu_unlock_asserts (
   .SYS_CLK  (SYS_CLK),
   .RST_N    (RST_N),
   .HW_RESET (HW_RESET),
   .ADDR     (ADDR),
   .WDATA    (WDATA),
   .WR       (WR),
   .RD       (RD),
   .RDATA    (RDATA),
   .IRQ      (IRQ),
   .LOCKED   (LOCKED)
);
`default_nettype wire

// >>> asu_host.sv
// host controller model driving the block's register port
`timescale 1ns/1ps
`default_nettype none
module asu_host
   import asu_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic [15:0] RDATA,
   output logic      [3:0]  ADDR,
   output logic      [15:0] WDATA,
   output logic             WR,
   output logic             RD
);
   // bus idle at time zero
   initial begin
      ADDR  = 4'h0;
      WDATA = 16'h0000;
      WR    = 1'b0;
      RD    = 1'b0;
   end

   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge SYS_CLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge SYS_CLK);
      WR    <= 1'b0;
      WDATA <= ~d;  // a released bus does not keep the last word
   endtask : wr

   // one-cycle read strobe, data taken mid-way through the next cycle
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge SYS_CLK);
      RD   <= 1'b0;
      @(negedge SYS_CLK);
      d = RDATA;
   endtask : rd

   // password sector: control word, 16 key words, reserved junk words
   task automatic sector(input logic [15:0] ctrl, input logic [7:0] key,
                         input int first, input int last);
      logic [15:0] v;
      for (int w = first; w <= last; w++) begin
         v = (w == 0) ? ctrl : (w <= 16) ? {key, 8'(w)} : 16'hA5A5;
         wr(ASU_A_DATA, v);
      end
   endtask : sector
endmodule : asu_host
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the security unlock command block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import asu_pkg::*;
;
   logic        sys_clk  = 1'b0;  // 200 MHz
   logic        rst_n    = 1'b0;  // power-on reset
   logic        hw_reset = 1'b0;  // hardware reset pulse
   logic [3:0]  addr;             // bus signals from host model
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic        irq;
   logic        locked;
   logic [15:0] st;               // last register read
   int          n_mismatch = 0;
   int          compares   = 0;
   int          cycles     = 0;
   // seek table: {out of range, command, drive/head, cyl low, sector}
   logic [32:0] seeks [7] = '{33'h0_70A3_0F04, 33'h1_71A3_0F05,
      33'h1_72A0_0000, 33'h1_73A4_0001, 33'h1_74A0_1001,
      33'h0_7FE0_00FF, 33'h1_7EE0_0100};

   always #2.5 sys_clk = ~sys_clk;

   asu_unlock i_asu_unlock (.SYS_CLK(sys_clk), .RST_N(rst_n),
      .HW_RESET(hw_reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .IRQ(irq), .LOCKED(locked));
   asu_host i_asu_host (.SYS_CLK(sys_clk), .RDATA(rdata), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd));

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic chk(input string name, input logic [15:0] seen,
                      input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // flags {abort, idnf, locked, enabled, level max}; err follows both
   function automatic logic [15:0] st_of(input logic [4:0] f,
                                         input logic [2:0] tr);
      return {5'h00, tr, f[0], f[1], f[2], f[3], f[4], f[4] | f[3], 2'h0};
   endfunction : st_of

   // command (none if zero), optional sector, poll busy, compare status
   task automatic run(input logic [7:0] cmd, input logic [15:0] ctrl,
                      input logic [7:0] key, input int nw,
                      input logic [4:0] f, input logic [2:0] tr);
      int n;
      if (cmd != 8'h00)
         i_asu_host.wr(ASU_A_COMMAND, {8'h00, cmd});
      if (nw > 0)
         i_asu_host.sector(ctrl, key, 0, nw - 1);
      n  = 0;
      st = 16'h0001;
      while (st[ASU_S_BUSY] !== 1'b0 && n < 50) begin
         i_asu_host.rd(ASU_A_STATUS, st);
         n++;
      end
      chk("status", st & 16'h07FC, st_of(f, tr));
   endtask : run

   // hardware reset pulse, then lock and counter through the status port
   task automatic hw(input logic lk);
      @(posedge sys_clk);
      hw_reset <= 1'b1;
      @(posedge sys_clk);
      hw_reset <= 1'b0;
      i_asu_host.rd(ASU_A_STATUS, st);
      chk("reset status", st & 16'h0720,
          {5'h00, ASU_TRIES_INIT, 2'h0, lk, 5'h00});
      chk("lock pin", {15'h0000, locked}, {15'h0000, lk});
   endtask : hw

   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   // hang guard, the whole run needs about nine thousand cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_mismatch++;
         final_report();
      end
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      i_asu_host.rd(ASU_A_STATUS, st);
      chk("power-on status", st, st_of(5'h00, 3'h5));
      i_asu_host.rd(4'hD, st);
      chk("unmapped", st, 16'h0000);
      i_asu_host.rd(ASU_A_DATA, st);
      chk("data read", st, 16'h0000);
      i_asu_host.rd(ASU_A_CAP_HS, st);
      chk("cap", st, {4'h0, ASU_CAP_HDS_RST, ASU_CAP_SPT_RST});
      i_asu_host.wr(ASU_A_IRQ_MSK, 16'h0007);
      run(ASU_CMD_UNLOCK, 16'h0000, 8'h09, 256, 5'h10, 3'h5);
      chk("irq", {15'h0000, irq}, 16'h0001);
      i_asu_host.rd(ASU_A_IRQ_ST, st);
      chk("events", st, 16'h0007);
      i_asu_host.wr(ASU_A_IRQ_MSK, 16'h0000);
      repeat (3) @(negedge sys_clk);
      chk("irq masked", {15'h0000, irq}, 16'h0000);
      i_asu_host.wr(ASU_A_IRQ_MSK, 16'h0007);
      repeat (3) @(negedge sys_clk);
      chk("irq unmasked", {15'h0000, irq}, 16'h0001);
      i_asu_host.wr(ASU_A_IRQ_ST, 16'h0007);
      repeat (3) @(negedge sys_clk);
      chk("irq cleared", {15'h0000, irq}, 16'h0000);
      // master set, then user at high level
      run(ASU_CMD_SET_PW, 16'h0001, 8'h3C, 256, 5'h00,
          3'h5);
      run(ASU_CMD_SET_PW, 16'h0000, 8'h5A, 256, 5'h02, 3'h5);
      chk("lock pin", {15'h0000, locked}, 16'h0000);
      hw(1'b1);
      run(ASU_CMD_UNLOCK, 16'h0000, 8'h09, 256, 5'h16,
          3'h4);
      // master unlock, lock held until the whole sector is taken
      i_asu_host.wr(ASU_A_COMMAND, {8'h00, ASU_CMD_UNLOCK});
      i_asu_host.sector(16'h0001, 8'h3C, 0, 254);
      i_asu_host.rd(ASU_A_STATUS, st);
      chk("mid sector", st & 16'h0023, 16'h0023);
      i_asu_host.sector(16'h0001, 8'h3C, 255, 255);
      run(8'h00, 16'h0000, 8'h00, 0, 5'h02, 3'h4);
      hw(1'b1);
      run(ASU_CMD_UNLOCK, 16'h0000, 8'h5A, 256, 5'h02, 3'h5);
      // user password at maximum level shuts the master out
      run(ASU_CMD_SET_PW, 16'h0100, 8'h5A, 256, 5'h03, 3'h5);
      hw(1'b1);
      run(ASU_CMD_UNLOCK, 16'h0001, 8'h3C, 256, 5'h17,
          3'h5);
      run(ASU_CMD_UNLOCK, 16'h0000, 8'h5A, 256, 5'h03, 3'h5);
      // exhaust the attempt counter
      hw(1'b1);
      for (int i = 1; i <= 5; i++) begin
         run(ASU_CMD_UNLOCK, 16'h0000, 8'h09, 256, 5'h17,
             3'(5 - i));
      end
      run(ASU_CMD_UNLOCK, 16'h0000, 8'h5A, 256, 5'h17, 3'h0);
      run(ASU_CMD_ERASE, 16'h0000, 8'h5A, 256, 5'h17, 3'h0);
      hw(1'b1);
      run(ASU_CMD_UNLOCK, 16'h0000, 8'h5A, 256, 5'h03, 3'h5);
      // seek range checks in both addressing modes
      for (int i = 0; i < 7; i++) begin
         i_asu_host.wr(ASU_A_DEVHEAD, {8'h00, seeks[i][23:16]});
         i_asu_host.wr(ASU_A_CYL_HI, 16'h0000);
         i_asu_host.wr(ASU_A_CYL_LO, {8'h00, seeks[i][15:8]});
         i_asu_host.wr(ASU_A_SECT, {8'h00, seeks[i][7:0]});
         run(seeks[i][31:24], 16'h0000, 8'h00, 0,
             seeks[i][32] ? 5'h0B : 5'h03, 3'h5);
         i_asu_host.rd(ASU_A_SECT, st);
         chk("sector reg", st, {8'h00, seeks[i][7:0]});
      end
      final_report();
   end
endmodule : testbench
`default_nettype wire
